// ### dv/lfocal_osc_model.sv
// Behavioural fast and slow oscillators, as levels stepped on the reference clock.
// Assumes the fast half period is at least two reference cycles.
module lfocal_osc_model (
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_fast_on,
  input  wire logic [7:0]              i_fast_half,
  input  wire logic [7:0]              i_slow_half,
  output lfocal_pkg::lfocal_osc_s      o_osc
);
  timeunit 1ns;
  timeprecision 100ps;
  import lfocal_pkg::*;
  logic [7:0]  fast_cnt = 8'h00;
  logic [7:0]  slow_cnt = 8'h00;
  lfocal_osc_s osc_q    = '0;
  assign o_osc = osc_q;
  // Slow oscillator free-runs; fast one stands low while switched off
  always @(posedge i_ref_clk) begin
    osc_q.fast_osc_on <= i_fast_on;
    slow_cnt <= (slow_cnt + 8'h01 >= i_slow_half) ? 8'h00 : slow_cnt + 8'h01;
    if (slow_cnt + 8'h01 >= i_slow_half) osc_q.slow_clock <= !osc_q.slow_clock;
    fast_cnt <= (!i_fast_on || fast_cnt + 8'h01 >= i_fast_half) ? 8'h00 : fast_cnt + 8'h01;
    if (!i_fast_on) osc_q.fast_clock <= 1'b0;
    else if (fast_cnt + 8'h01 >= i_fast_half) osc_q.fast_clock <= !osc_q.fast_clock;
  end
endmodule // lfocal_osc_model

// ### dv/lfocal_sva.sv
// Concurrent checks on the ports of the oscillator calibration block.
// Assumes registers change only through the plain bus port of lfocal_top.
module lfocal_sva (
  input wire logic                     i_ref_clk,
  input wire logic                     i_reset,
  input wire lfocal_pkg::lfocal_bus_s  i_bus,
  input wire lfocal_pkg::lfocal_osc_s  i_osc,
  input wire logic [lfocal_pkg::DATA_W-1:0] o_rdata,
  input wire logic [5:0]               o_osc_trim_code,
  input wire logic                     o_irq
);
  import lfocal_pkg::*;
  logic [6:0] ctrl_q;
  logic [5:0] lower_q;
  wire        wr_trim = i_bus.wr && (i_bus.addr == OFS_TRIM_VALUE);
  // Shadow copies, so trim checks can use the control and floor settings
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_q  <= CONTROL_RST;
      lower_q <= TRIM_LOWER_RST;
    end else begin
      if (i_bus.wr && i_bus.addr == OFS_CALIB_CONTROL) ctrl_q <= i_bus.wdata[6:0];
      if (i_bus.wr && i_bus.addr == OFS_TRIM_LOWER_LIMIT) lower_q <= i_bus.wdata[5:0];
    end
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  property p_upper_ro;
    i_bus.rd && i_bus.addr == OFS_TRIM_UPPER_LIMIT |=> o_rdata == 16'h003F;
  endproperty
  a_upper_ro: assert property (p_upper_ro) else $error("upper limit read wrong");
  property p_trim_write;
    wr_trim |=> o_osc_trim_code == (($past(i_bus.wdata[7:0]) > 8'h3F) ? 6'h3F : $past(i_bus.wdata[5:0]));
  endproperty
  a_trim_write: assert property (p_trim_write) else $error("trim write not clamped");
  property p_trim_step;
    !$past(wr_trim) && o_osc_trim_code != $past(o_osc_trim_code) |->
      o_osc_trim_code == $past(o_osc_trim_code) + 6'h01 || o_osc_trim_code == $past(o_osc_trim_code) - 6'h01;
  endproperty
  a_trim_step: assert property (p_trim_step) else $error("trim moved by more than one");
  property p_trim_abort;
    !$past(i_osc.fast_osc_on) && !i_osc.fast_osc_on && !wr_trim |=> $stable(o_osc_trim_code);
  endproperty
  a_trim_abort: assert property (p_trim_abort) else $error("trim moved with fast osc off");
  property p_trim_hold;
    ctrl_q[CTRL_HOLD_TRIM_BIT] && !wr_trim |=> $stable(o_osc_trim_code);
  endproperty
  a_trim_hold: assert property (p_trim_hold) else $error("trim moved while held");
  property p_trim_floor;
    o_osc_trim_code < $past(o_osc_trim_code) && !$past(wr_trim) |-> o_osc_trim_code >= $past(lower_q);
  endproperty
  a_trim_floor: assert property (p_trim_floor) else $error("trim stepped below floor");
  property p_irq_off;
    ctrl_q[3:0] == 4'h0 |-> !o_irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq with all enables off");
  property p_ctrl_read;
    i_bus.rd && i_bus.addr == OFS_CALIB_CONTROL |=> o_rdata == {9'h000, ctrl_q};
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control readback wrong");
  c_step_up: cover property (!$past(wr_trim) && o_osc_trim_code == $past(o_osc_trim_code) + 6'h01);
  c_step_down: cover property (!$past(wr_trim) && o_osc_trim_code == $past(o_osc_trim_code) - 6'h01);
  c_irq: cover property ($rose(o_irq));
endmodule // lfocal_sva

bind lfocal_top lfocal_sva u_sva (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_bus(i_bus), .i_osc(i_osc),
  .o_rdata(o_rdata), .o_osc_trim_code(o_osc_trim_code), .o_irq(o_irq));

// ### dv/lfocal_tb_top.sv
// Self-checking bench: register bus tasks, calibration cycles and aborts.
// Assumes 20 fast periods per slow period from the oscillator model.
module lfocal_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import lfocal_pkg::*;
  logic        i_ref_clk;
  logic        i_reset;
  lfocal_bus_s bus;
  lfocal_osc_s osc;
  logic [15:0] rdata;
  logic [5:0]  trim;
  logic        irq;
  logic        fast_on;
  int          n_fail;
  int          n_tests;
  lfocal_osc_model u_osc (.i_ref_clk(i_ref_clk), .i_fast_on(fast_on), .i_fast_half(8'h02),
    .i_slow_half(8'h28), .o_osc(osc));
  lfocal_top uut (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_bus(bus), .i_osc(osc),
    .o_rdata(rdata), .o_osc_trim_code(trim), .o_irq(irq));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge i_ref_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_ref_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [15:0] exp);
    @(posedge i_ref_clk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge i_ref_clk);
    bus.rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic run_cycle(input logic [15:0] ctrl, input logic [15:0] expc, input logic [15:0] st,
      input logic [15:0] tr);
    int k;
    wr(OFS_FAST_COUNT_EXPECTED, expc);
    wr(OFS_CALIB_CONTROL, ctrl);
    k = 0;
    while (irq !== 1'b1 && k < 1000) begin
      @(posedge i_ref_clk);
      k++;
    end
    if (k >= 1000) begin
      n_fail++;
      $display("MISMATCH t=%0t cycle timeout got=%h exp=%h", $time, irq, 1'b1);
      give_verdict();
    end
    rd_chk(OFS_CALIB_STATUS, st);
    rd_chk(OFS_CALIB_STATUS, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
    rd_chk(OFS_TRIM_VALUE, tr);
  endtask
  task automatic t_reset();
    logic [5:0]  at [10] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14, 6'h18, 6'h1C, 6'h20, 6'h24};
    logic [15:0] vt [10] = '{16'h0, 16'h0, 16'h3F, 16'h0, 16'h20, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
    wr(OFS_TRIM_UPPER_LIMIT, 16'h0000);
    wr(OFS_SLOW_PERIOD_COUNT, 16'h0005);
    for (int i = 0; i < 10; i++) begin
      rd_chk(at[i], vt[i]);
    end
    $display("test reset values done");
  endtask
  task automatic t_regs();
    wr(OFS_TRIM_LOWER_LIMIT, 16'h0015);
    rd_chk(OFS_TRIM_LOWER_LIMIT, 16'h0015);
    wr(OFS_TRIM_VALUE, 16'h0055);
    rd_chk(OFS_TRIM_VALUE, 16'h003F);
    chk({10'h000, trim}, 16'h003F);
    wr(OFS_CALIB_CONTROL, 16'h006F);
    rd_chk(OFS_CALIB_CONTROL, 16'h006F);
    wr(OFS_CALIB_CONTROL, 16'h0000);
    wr(OFS_TRIM_LOWER_LIMIT, 16'h0000);
    $display("test register access done");
  endtask
  task automatic t_steps();
    wr(OFS_SLOW_PERIOD_TARGET, 16'h0002);
    wr(OFS_TRIM_VALUE, 16'h0020);
    run_cycle(16'h0011, 16'd20, 16'h0011, 16'h0021);
    rd_chk(OFS_SLOW_PERIOD_COUNT, 16'h0002);
    run_cycle(16'h0031, 16'd80, 16'h0021, 16'h0020);
    run_cycle(16'h0031, 16'd60, 16'h0001, 16'h0020);
    run_cycle(16'h0011, 16'd60, 16'h0021, 16'h001F);
    run_cycle(16'h0011, 16'd40, 16'h0001, 16'h001F);
    run_cycle(16'h0051, 16'd20, 16'h0011, 16'h001F);
    $display("test trim steps done");
  endtask
  task automatic t_limits();
    wr(OFS_TRIM_LOWER_LIMIT, 16'h001F);
    run_cycle(16'h0019, 16'd80, 16'h0029, 16'h001F);
    wr(OFS_TRIM_VALUE, 16'h003F);
    run_cycle(16'h0015, 16'd20, 16'h0015, 16'h003F);
    $display("test trim limits done");
  endtask
  task automatic t_abort();
    wr(OFS_FAST_COUNT_EXPECTED, 16'd80);
    wr(OFS_CALIB_CONTROL, 16'h0011);
    repeat (100) @(posedge i_ref_clk);
    fast_on <= 1'b0;
    repeat (400) @(posedge i_ref_clk);
    rd_chk(OFS_CALIB_STATUS, 16'h0000);
    rd_chk(OFS_TRIM_VALUE, 16'h003F);
    fast_on <= 1'b1;
    wr(OFS_SLOW_PERIOD_TARGET, 16'h0000);
    wr(OFS_CALIB_CONTROL, 16'h0011);
    repeat (400) @(posedge i_ref_clk);
    rd_chk(OFS_CALIB_STATUS, 16'h0000);
    $display("test aborts done");
  endtask
  initial begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = !i_ref_clk;
  end
  initial begin
    n_fail = 0;
    n_tests = 0;
    i_reset = 1'b1;
    bus = '0;
    fast_on = 1'b1;
    repeat (10) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    t_reset();
    t_regs();
    t_steps();
    t_limits();
    t_abort();
    give_verdict();
  end
endmodule // lfocal_tb_top

// ### src/lfocal_pkg.sv
// Constants, register map and carrier types of the low frequency oscillator calibration block.
// Assumes a single 40 MHz reference clock and synchronous register and oscillator inputs.
package lfocal_pkg;

  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 16;

  // Register byte offsets
  localparam logic [5:0] OFS_CALIB_STATUS        = 6'h00;
  localparam logic [5:0] OFS_CALIB_CONTROL       = 6'h04;
  localparam logic [5:0] OFS_TRIM_UPPER_LIMIT    = 6'h08;
  localparam logic [5:0] OFS_TRIM_LOWER_LIMIT    = 6'h0C;
  localparam logic [5:0] OFS_TRIM_VALUE          = 6'h10;
  localparam logic [5:0] OFS_SLOW_PERIOD_TARGET  = 6'h14;
  localparam logic [5:0] OFS_SLOW_PERIOD_COUNT   = 6'h18;
  localparam logic [5:0] OFS_FAST_COUNT_EXPECTED = 6'h1C;
  localparam logic [5:0] OFS_FAST_COUNT_CAPTURED = 6'h20;

  // Control field positions
  localparam int unsigned CTRL_HOLD_TRIM_BIT  = 6;
  localparam int unsigned CTRL_TOL_SELECT_BIT = 5;
  localparam int unsigned CTRL_ENABLE_BIT     = 4;
  localparam int unsigned CTRL_IRQ_EN_W       = 4;
  localparam int unsigned CTRL_W              = 7;

  // Status field positions
  localparam int unsigned STAT_LAST_STEP_DOWN   = 5;
  localparam int unsigned STAT_LAST_STEP_UP     = 4;
  localparam int unsigned STAT_LOWER_LIMIT_HIT  = 3;
  localparam int unsigned STAT_UPPER_LIMIT_HIT  = 2;
  localparam int unsigned STAT_FAST_CNT_OVF     = 1;
  localparam int unsigned STAT_CYCLE_DONE       = 0;
  localparam int unsigned STAT_W                = 6;

  // Reset values
  localparam logic [STAT_W-1:0] STATUS_RST        = 6'h00;
  localparam logic [CTRL_W-1:0] CONTROL_RST       = 7'h00;
  localparam logic [5:0]        TRIM_UPPER_FACTORY = 6'h3F;
  localparam logic [5:0]        TRIM_LOWER_RST    = 6'h00;
  localparam logic [5:0]        TRIM_VALUE_RST    = 6'h20;
  localparam logic [2:0]        SLOW_TARGET_RST   = 3'h0;
  localparam logic [2:0]        SLOW_COUNT_RST    = 3'h0;
  localparam logic [12:0]       FAST_EXPECTED_RST = 13'h0000;
  localparam logic [12:0]       FAST_COUNT_RST    = 13'h0000;
  localparam logic [12:0]       FAST_COUNT_MAX    = 13'h1FFF;
  localparam logic [15:0]       RDATA_RST         = 16'h0000;

  // Comparison bands, 16 * (1 + tolerance_select)
  localparam logic [13:0] TOL_TIGHT = 14'h0010;
  localparam logic [13:0] TOL_WIDE  = 14'h0020;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ARM   = 2'b01,
    ST_COUNT = 2'b10,
    ST_EVAL  = 2'b11
  } lfocal_state_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } lfocal_bus_s;

  typedef struct packed {
    logic fast_clock;
    logic slow_clock;
    logic fast_osc_on;
  } lfocal_osc_s;

endpackage : lfocal_pkg

// ### src/lfocal_top.sv
// Low frequency oscillator calibration: counts fast clock cycles over a number of slow clock
// periods, compares against an expected count and steps the oscillator trim code by one.
// Assumes both oscillator clocks arrive as levels synchronous to i_ref_clk (fast clock below 20 MHz).
//
// Functional notes
// (RULE_01) Enabled cycle counts fast clocks, then compares
// (RULE_02) Tolerance select: clear 16, set 32 counts
// (RULE_03) Count above band steps trim up
// (RULE_04) Count below band steps trim down
// (RULE_05) Count inside band leaves trim unchanged
// (RULE_06) Software repeats cycles until settled or limited
// (RULE_07) Upper limit read-only, factory value 0x3F
// (RULE_08) Trim written above limit clamps to limit
// (RULE_09) Lower limit read/write, reset 0x00
// (RULE_10) Fast oscillator off aborts cycle, trim kept
// (RULE_11) Reading status clears all its flags
// (RULE_12) Bit 5 flags a decrement request, even blocked
// (RULE_13) Bit 4 flags an increment request, even blocked
// (RULE_14) Bits 3/2 flag lower/upper limit reached
// (RULE_15) Bit 1 flags fast counter overflow
// (RULE_16) Bit 0 flags one cycle completed
// (RULE_17) Control bit 6 holds trim at cycle end
// (RULE_18) Control bit 4 enables the calibration block
// (RULE_19) Control bits 3..0 enable each interrupt
// (RULE_20) Software writes zero to control bit 7
// (RULE_21) Software loads expected count from frequency ratio
// (RULE_22) Slow target three bits, zero disables counting
// (RULE_23) Six-bit trim never stepped below lower limit
// (RULE_24) Interrupt when any flag and enable set
//
// Chosen here: the plain strobed port.
module lfocal_top (
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_reset,
  input  wire lfocal_pkg::lfocal_bus_s   i_bus,
  input  wire lfocal_pkg::lfocal_osc_s   i_osc,
  output logic [lfocal_pkg::DATA_W-1:0]  o_rdata,
  output logic [5:0]                     o_osc_trim_code,
  output logic                           o_irq
);
  import lfocal_pkg::*;

  lfocal_state_e            state_q;
  lfocal_state_e            state_d;
  logic [CTRL_W-1:0]        ctrl_q;
  logic [5:0]               lower_q;
  logic [5:0]               trim_q;
  logic [5:0]               trim_d;
  logic [2:0]               slow_tgt_q;
  logic [2:0]               slow_cnt_q;
  logic [2:0]               slow_cnt_d;
  logic [12:0]              fast_exp_q;
  logic [12:0]              fast_cnt_q;
  logic [12:0]              fast_cnt_d;
  logic [STAT_W-1:0]        flags_q;
  logic [STAT_W-1:0]        flags_d;
  logic [STAT_W-1:0]        flag_set;
  logic                     fast_prev_q;
  logic                     slow_prev_q;
  logic [DATA_W-1:0]        rdata_q;

  // Bus decode
  wire wr_ctrl    = i_bus.wr && (i_bus.addr == OFS_CALIB_CONTROL);
  wire wr_lower   = i_bus.wr && (i_bus.addr == OFS_TRIM_LOWER_LIMIT);
  wire wr_trim    = i_bus.wr && (i_bus.addr == OFS_TRIM_VALUE);
  wire wr_tgt     = i_bus.wr && (i_bus.addr == OFS_SLOW_PERIOD_TARGET);
  wire wr_exp     = i_bus.wr && (i_bus.addr == OFS_FAST_COUNT_EXPECTED);
  wire rd_status  = i_bus.rd && (i_bus.addr == OFS_CALIB_STATUS);

  // Oscillator edges
  wire fast_rise  = i_osc.fast_clock & ~fast_prev_q;
  wire slow_rise  = i_osc.slow_clock & ~slow_prev_q;

  // Control fields
  wire hold_trim        = ctrl_q[CTRL_HOLD_TRIM_BIT];
  wire tolerance_select = ctrl_q[CTRL_TOL_SELECT_BIT];
  wire calib_enable     = ctrl_q[CTRL_ENABLE_BIT];

  // A write of the control word with the enable bit set, the fast oscillator on and a nonzero slow target launches one cycle
  wire start_cycle = wr_ctrl && i_bus.wdata[CTRL_ENABLE_BIT] && i_osc.fast_osc_on
                     && (slow_tgt_q != SLOW_TARGET_RST);                                   // [RULE_18] [RULE_22]
  // Losing the fast clock, the enable or the target drops the cycle with no trim change
  wire abort_cycle = ~i_osc.fast_osc_on || ~calib_enable
                     || (slow_tgt_q == SLOW_TARGET_RST);                                   // [RULE_10] [RULE_22]

  wire counting   = (state_q == ST_COUNT);
  wire slow_last  = slow_rise && (slow_cnt_q + 3'h1 == slow_tgt_q);
  wire fast_ovf   = counting && fast_rise && (fast_cnt_q == FAST_COUNT_MAX);
  wire eval_now   = (state_q == ST_EVAL);

  // Comparison, widened one bit so the band never wraps
  wire [13:0] tol_band  = tolerance_select ? TOL_WIDE : TOL_TIGHT;                         // [RULE_02]
  wire [13:0] cnt_wide  = {1'b0, fast_cnt_q};
  wire [13:0] exp_wide  = {1'b0, fast_exp_q};
  wire        need_up   = cnt_wide > (exp_wide + tol_band);                                // [RULE_03]
  wire        need_down = (cnt_wide + tol_band) < exp_wide;                                // [RULE_04]

  wire do_up    = eval_now && need_up && ~hold_trim && (trim_q < TRIM_UPPER_FACTORY);      // [RULE_03] [RULE_17]
  wire do_down  = eval_now && need_down && ~hold_trim && (trim_q > lower_q);               // [RULE_04] [RULE_17] [RULE_23]
  wire [5:0] trim_after = do_up ? (trim_q + 6'h01) : (do_down ? (trim_q - 6'h01) : trim_q); // [RULE_05]

  // Software trim writes above the factory ceiling fall back to it; the whole byte is
  // compared, since a six-bit slice can never exceed the ceiling
  wire [5:0] trim_wr_val = (i_bus.wdata[7:0] > {2'b00, TRIM_UPPER_FACTORY}) ? TRIM_UPPER_FACTORY
                                                                            : i_bus.wdata[5:0]; // [RULE_08]

  // Event sources for status flags
  assign flag_set[STAT_CYCLE_DONE]      = eval_now;                                        // [RULE_16]
  assign flag_set[STAT_FAST_CNT_OVF]    = fast_ovf;                                        // [RULE_15]
  assign flag_set[STAT_UPPER_LIMIT_HIT] = eval_now && need_up
                                          && (trim_after >= TRIM_UPPER_FACTORY);           // [RULE_14]
  assign flag_set[STAT_LOWER_LIMIT_HIT] = eval_now && need_down && (trim_after <= lower_q); // [RULE_14]
  assign flag_set[STAT_LAST_STEP_UP]    = eval_now && need_up;                             // [RULE_13]
  assign flag_set[STAT_LAST_STEP_DOWN]  = eval_now && need_down;                           // [RULE_12]

  // Clear on read, but an event in the same cycle survives the read
  genvar g;
  generate
    for (g = 0; g < STAT_W; g++) begin : g_flag
      assign flags_d[g] = flag_set[g] | (flags_q[g] & ~rd_status);                         // [RULE_11]
    end
  endgenerate

  // Sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start_cycle) begin
          state_d = ST_ARM;
        end
      end
      ST_ARM: begin
        if (abort_cycle) begin
          state_d = ST_IDLE;
        end else if (slow_rise) begin
          state_d = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (abort_cycle) begin
          state_d = ST_IDLE;                                                               // [RULE_10]
        end else if (slow_last) begin
          state_d = ST_EVAL;                                                               // [RULE_01]
        end
      end
      ST_EVAL: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Counters: both restart on the slow edge that opens the window
  always_comb begin
    slow_cnt_d = slow_cnt_q;
    fast_cnt_d = fast_cnt_q;
    if ((state_q == ST_ARM) && slow_rise && ~abort_cycle) begin
      slow_cnt_d = SLOW_COUNT_RST;
      fast_cnt_d = FAST_COUNT_RST;
    end else if (counting && ~abort_cycle) begin
      if (slow_rise) begin
        slow_cnt_d = slow_cnt_q + 3'h1;
      end
      // Saturation keeps an overflowed window reading as too long, not wrapped short
      if (fast_rise && (fast_cnt_q != FAST_COUNT_MAX)) begin
        fast_cnt_d = fast_cnt_q + 13'h0001;                                                // [RULE_01]
      end
    end
  end

  // Cycle end step wins over a software write in the same cycle
  always_comb begin
    trim_d = trim_q;
    if (eval_now) begin
      trim_d = trim_after;                                                                 // [RULE_03] [RULE_04]
    end else if (wr_trim) begin
      trim_d = trim_wr_val;                                                                // [RULE_08]
    end
  end

  // Read mux; the upper limit is a constant, so writes to it go nowhere
  wire [DATA_W-1:0] rd_mux =
      (i_bus.addr == OFS_CALIB_STATUS)        ? {10'h000, flags_q}          :
      (i_bus.addr == OFS_CALIB_CONTROL)       ? {9'h000, ctrl_q}            :
      (i_bus.addr == OFS_TRIM_UPPER_LIMIT)    ? {10'h000, TRIM_UPPER_FACTORY} :            // [RULE_07]
      (i_bus.addr == OFS_TRIM_LOWER_LIMIT)    ? {10'h000, lower_q}          :
      (i_bus.addr == OFS_TRIM_VALUE)          ? {10'h000, trim_q}           :
      (i_bus.addr == OFS_SLOW_PERIOD_TARGET)  ? {13'h0000, slow_tgt_q}      :
      (i_bus.addr == OFS_SLOW_PERIOD_COUNT)   ? {13'h0000, slow_cnt_q}      :
      (i_bus.addr == OFS_FAST_COUNT_EXPECTED) ? {3'h0, fast_exp_q}          :
      (i_bus.addr == OFS_FAST_COUNT_CAPTURED) ? {3'h0, fast_cnt_q}          :
                                                RDATA_RST;

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      state_q     <= ST_IDLE;
      fast_prev_q <= 1'b0;
      slow_prev_q <= 1'b0;
      slow_cnt_q  <= SLOW_COUNT_RST;
      fast_cnt_q  <= FAST_COUNT_RST;
      trim_q      <= TRIM_VALUE_RST;
      flags_q     <= STATUS_RST;
    end else begin
      state_q     <= state_d;
      fast_prev_q <= i_osc.fast_clock;
      slow_prev_q <= i_osc.slow_clock;
      slow_cnt_q  <= slow_cnt_d;
      fast_cnt_q  <= fast_cnt_d;
      trim_q      <= trim_d;
      flags_q     <= flags_d;
    end
  end

  // Software registers; reserved bits are dropped so they read as zero
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_q     <= CONTROL_RST;
      lower_q    <= TRIM_LOWER_RST;
      slow_tgt_q <= SLOW_TARGET_RST;
      fast_exp_q <= FAST_EXPECTED_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= i_bus.wdata[CTRL_W-1:0];                                                 // [RULE_18] [RULE_19]
      end
      if (wr_lower) begin
        lower_q <= i_bus.wdata[5:0];                                                       // [RULE_09]
      end
      if (wr_tgt) begin
        slow_tgt_q <= i_bus.wdata[2:0];                                                    // [RULE_22]
      end
      if (wr_exp) begin
        fast_exp_q <= i_bus.wdata[12:0];
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      rdata_q <= RDATA_RST;
    end else begin
      rdata_q <= i_bus.rd ? rd_mux : RDATA_RST;
    end
  end

  assign o_rdata         = rdata_q;
  assign o_osc_trim_code = trim_q;
  assign o_irq           = |(flags_q[CTRL_IRQ_EN_W-1:0] & ctrl_q[CTRL_IRQ_EN_W-1:0]);      // [RULE_19] [RULE_24]

endmodule : lfocal_top
